// ===== hw/dbf_fetch.sv
/*
  dbf_fetch: break-request, arbitration, fetch stop and double-bank line buffer.
  assumes bus timing pulses are one pclk wide and synchronous to pclk.
*/
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module dbf_fetch (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // backplane timing and video timing chain
  input wire dbf_pkg::dbf_timing_type timing,
  input wire dbf_pkg::dbf_video_type video,
  input wire logic end_screen_code_hit,
  // backplane data and memory lines
  input wire logic [dbf_pkg::WORD_W-1:0] data_in,
  output logic [dbf_pkg::WORD_W-1:0] data_out,
  output logic [dbf_pkg::WORD_W-1:0] data_oe,
  input wire logic [dbf_pkg::WORD_W-1:0] md_in,
  output logic [dbf_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_addr_oe,
  output dbf_pkg::dbf_busctl_type busctl,
  // line buffer output to video
  output logic [dbf_pkg::WORD_W-1:0] video_word,
  output logic read_select
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic graphic_mode_select;
    logic chars64;
    logic [1:0] prio_sel;
    logic maintenance_hold;
    logic maint_pend;
    logic armed;
    logic counting;
    logic break_request_flop;
    logic priority_won;
    logic grant_stage_a;
    logic grant_stage_b;
    logic grant_stage_c;
    logic newline_flag;
    logic finish_shift_flag;
    logic overflowed;
    logic bank_alt;
    logic read_sel;
    logic [dbf_pkg::BRK_CNT_W-1:0] brk_cnt;
    logic [dbf_pkg::CNT_W-1:0] char_cnt;
    logic [dbf_pkg::ADDR_W-1:0] addr;
    logic [dbf_pkg::WORD_W-1:0] vid;
    logic [31:0] rdata;
    logic [dbf_pkg::BANK_DEPTH-1:0][dbf_pkg::WORD_W-1:0] bank_a;
    logic [dbf_pkg::BANK_DEPTH-1:0][dbf_pkg::WORD_W-1:0] bank_b;
  } dbf_state_type;

  dbf_state_type st_r;
  dbf_state_type st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [dbf_pkg::WORD_W-1:0] dbf_own_line(input logic [1:0] p);
    unique case (p)
      dbf_pkg::PRIO_10: dbf_own_line = dbf_pkg::PRIO_LINE_10;
      dbf_pkg::PRIO_11: dbf_own_line = dbf_pkg::PRIO_LINE_11;
      default: dbf_own_line = dbf_pkg::PRIO_LINE_12;
    endcase
  endfunction : dbf_own_line

  function automatic logic [dbf_pkg::WORD_W-1:0] dbf_higher(input logic [1:0] p);
    unique case (p)
      dbf_pkg::PRIO_10: dbf_higher = dbf_pkg::HIGHER_10;
      dbf_pkg::PRIO_11: dbf_higher = dbf_pkg::HIGHER_11;
      default: dbf_higher = dbf_pkg::HIGHER_12;
    endcase
  endfunction : dbf_higher

  function automatic logic [dbf_pkg::BANK_DEPTH-1:0][dbf_pkg::WORD_W-1:0] dbf_shift(
    input logic [dbf_pkg::BANK_DEPTH-1:0][dbf_pkg::WORD_W-1:0] bank,
    input logic load_en,
    input logic [dbf_pkg::WORD_W-1:0] word
  );
    dbf_shift = {bank[0], bank[dbf_pkg::BANK_DEPTH-1:1]};
    if (load_en)
    begin
      dbf_shift[dbf_pkg::BANK_DEPTH-1] = word;
    end
  endfunction : dbf_shift

  ////////////////////////////////////////////////////////////////////////////
  // combinational

  logic apb_wr;
  logic apb_rd;
  logic mapped;
  logic break_burst_trigger;
  logic fetch_stop_request;
  logic count_pulse;
  logic at_limit;
  logic break_shift_pulse;
  logic bank_a_load_enable;
  logic bank_b_load_enable;
  logic shift_a;
  logic shift_b;
  logic [dbf_pkg::CNT_W-1:0] limit;

  assign pready = 1'b1;
  assign mapped = (paddr == dbf_pkg::ADDR_CTRL) || (paddr == dbf_pkg::ADDR_CMD) ||
                  (paddr == dbf_pkg::ADDR_STATUS) || (paddr == dbf_pkg::ADDR_START);
  assign pslverr = psel && penable && !mapped;
  assign apb_wr = psel && penable && pwrite && mapped;
  assign apb_rd = psel && !penable && !pwrite;

  always_comb
  begin
    st_nxt = st_r;
    limit = st_r.graphic_mode_select ? dbf_pkg::WORDS_GRAPHIC :
            (st_r.chars64 ? dbf_pkg::WORDS_ALPHA64 : dbf_pkg::WORDS_ALPHA32);

    // trigger generation
    if (st_r.graphic_mode_select)
    begin
      break_burst_trigger = st_r.armed && video.visible_frame_zone &&
                            video.line_end_tick && video.alternate_line_flag;
    end
    else
    begin
      break_burst_trigger = st_r.armed && video.visible_frame_zone && video.ten_line_carry;
    end

    fetch_stop_request = st_r.newline_flag || end_screen_code_hit || video.vsync;
    count_pulse = timing.timing_pulse_one && (st_r.grant_stage_a || st_r.finish_shift_flag);
    at_limit = (st_r.char_cnt == limit - 7'h01);
    break_shift_pulse = timing.timing_pulse_four && (st_r.grant_stage_b || st_r.finish_shift_flag);

    // bank steering
    bank_a_load_enable = 1'b0;
    bank_b_load_enable = 1'b0;
    shift_a = 1'b0;
    shift_b = 1'b0;
    if (st_r.graphic_mode_select)
    begin
      bank_a_load_enable = st_r.read_sel;
      bank_b_load_enable = !st_r.read_sel;
      shift_a = st_r.read_sel ? break_shift_pulse : video.shift_line_buffer;
      shift_b = st_r.read_sel ? video.shift_line_buffer : break_shift_pulse;
    end
    else if (st_r.chars64)
    begin
      bank_a_load_enable = break_shift_pulse && !st_r.bank_alt;
      bank_b_load_enable = break_shift_pulse && st_r.bank_alt;
      shift_a = (break_shift_pulse || video.shift_line_buffer) && !st_r.bank_alt;
      shift_b = (break_shift_pulse || video.shift_line_buffer) && st_r.bank_alt;
    end
    else
    begin
      bank_b_load_enable = break_shift_pulse;
      shift_b = break_shift_pulse || video.shift_line_buffer;
    end

    // line buffer shifting
    if (shift_a)
    begin
      st_nxt.bank_a = dbf_shift(st_r.bank_a, bank_a_load_enable, md_in);
    end
    if (shift_b)
    begin
      st_nxt.bank_b = dbf_shift(st_r.bank_b, bank_b_load_enable, md_in);
    end
    if (st_r.chars64 && !st_r.graphic_mode_select && (shift_a || shift_b))
    begin
      st_nxt.bank_alt = !st_r.bank_alt;
    end
    st_nxt.read_sel = st_r.graphic_mode_select ? st_r.read_sel :
                      (st_r.chars64 ? st_r.bank_alt : 1'b1);
    st_nxt.vid = st_r.read_sel ? st_r.bank_b[0] : st_r.bank_a[0];

    // fetch window and counters
    if (break_burst_trigger)
    begin
      st_nxt.counting = 1'b1;
      st_nxt.newline_flag = 1'b0;
      st_nxt.overflowed = 1'b0;
      if (st_r.graphic_mode_select)
      begin
        st_nxt.read_sel = !st_r.read_sel;
      end
    end
    if (count_pulse)
    begin
      st_nxt.brk_cnt = st_r.brk_cnt + 4'h1;
      if (at_limit)
      begin
        st_nxt.char_cnt = '0;
        st_nxt.counting = 1'b0;
        st_nxt.overflowed = 1'b1;
      end
      else
      begin
        st_nxt.char_cnt = st_r.char_cnt + 7'h01;
      end
    end

    // newline detection on fetched word
    if (st_r.grant_stage_c && (md_in == dbf_pkg::NEWLINE_CODE) &&
        !st_r.overflowed && !st_r.maintenance_hold)
    begin
      st_nxt.newline_flag = 1'b1;
    end

    // finish-shift sampled every pulse four
    if (timing.timing_pulse_four)
    begin
      st_nxt.finish_shift_flag = st_r.counting &&
        (st_r.finish_shift_flag || st_r.newline_flag || end_screen_code_hit);
    end

    // break request at interrupt strobe
    if (timing.int_strobe)
    begin
      st_nxt.break_request_flop = (st_r.counting && !st_r.maintenance_hold && !fetch_stop_request) ||
                                  st_r.maint_pend;
    end
    else if (fetch_stop_request && !st_r.maintenance_hold)
    begin
      st_nxt.break_request_flop = 1'b0;
    end

    // arbitration in time state four
    if (timing.time_state_four && st_r.break_request_flop)
    begin
      st_nxt.priority_won = !(|(data_in & dbf_higher(st_r.prio_sel)));
    end
    else if (!st_r.break_request_flop)
    begin
      st_nxt.priority_won = 1'b0;
    end
    if (timing.timing_pulse_four)
    begin
      st_nxt.grant_stage_a = st_r.break_request_flop && st_r.priority_won;
      st_nxt.grant_stage_b = st_r.break_request_flop && st_r.priority_won;
      // single break stays pending until its grant is taken
      if (st_r.break_request_flop && st_r.priority_won)
      begin
        st_nxt.maint_pend = 1'b0;
      end
      if (st_r.grant_stage_b)
      begin
        st_nxt.addr = st_r.addr + 15'h0001;
      end
    end
    if (!st_r.grant_stage_a)
    begin
      st_nxt.grant_stage_c = 1'b0;
    end
    else if (timing.timing_pulse_one)
    begin
      st_nxt.grant_stage_c = 1'b1;
    end

    // vertical sync rearms and clears sequencing
    if (video.vsync)
    begin
      st_nxt.armed = 1'b1;
      st_nxt.brk_cnt = '0;
      st_nxt.counting = 1'b0;
      st_nxt.char_cnt = '0;
      st_nxt.newline_flag = 1'b0;
    end

    // apb writes
    if (apb_wr && (paddr == dbf_pkg::ADDR_CTRL))
    begin
      st_nxt.graphic_mode_select = pwdata[dbf_pkg::CTRL_GRAPHIC];
      st_nxt.chars64 = pwdata[dbf_pkg::CTRL_CHARS64];
      st_nxt.prio_sel = pwdata[dbf_pkg::CTRL_PRIO_LO +: dbf_pkg::CTRL_PRIO_W];
    end
    if (apb_wr && (paddr == dbf_pkg::ADDR_CMD))
    begin
      if (pwdata[dbf_pkg::CMD_GO])
      begin
        st_nxt.maintenance_hold = 1'b0;
      end
      if (pwdata[dbf_pkg::CMD_MAINT_ON])
      begin
        st_nxt.maintenance_hold = 1'b1;
      end
      if (pwdata[dbf_pkg::CMD_MAINT_BRK])
      begin
        st_nxt.maint_pend = 1'b1;
      end
    end
    if (apb_wr && (paddr == dbf_pkg::ADDR_START))
    begin
      st_nxt.addr = pwdata[dbf_pkg::ADDR_W-1:0];
    end

    // apb read data captured in setup phase
    if (apb_rd)
    begin
      unique case (paddr)
        dbf_pkg::ADDR_CTRL: st_nxt.rdata = {28'h0000000, st_r.prio_sel, st_r.chars64, st_r.graphic_mode_select};
        dbf_pkg::ADDR_CMD: st_nxt.rdata = {29'h00000000, st_r.maintenance_hold, st_r.maint_pend, 1'b0};
        dbf_pkg::ADDR_STATUS: st_nxt.rdata = {9'h000, st_r.char_cnt, st_r.brk_cnt,
          st_r.read_sel, st_r.overflowed, st_r.newline_flag, st_r.finish_shift_flag,
          st_r.counting, st_r.armed, st_r.priority_won, st_r.grant_stage_c,
          st_r.grant_stage_b, st_r.grant_stage_a, st_r.break_request_flop, st_r.maintenance_hold};
        dbf_pkg::ADDR_START: st_nxt.rdata = {17'h00000, st_r.addr};
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.maintenance_hold <= 1'b1;
      st_r.prio_sel <= dbf_pkg::PRIO_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = st_r.rdata;
  assign busctl.cpu_addr_drive_off = st_r.break_request_flop;
  assign busctl.break_pending_line = st_r.break_request_flop;
  assign busctl.cpu_dma_state_force = st_r.grant_stage_a;
  assign busctl.break_cycle_ind = st_r.grant_stage_a;
  assign busctl.mem_data_direction = st_r.grant_stage_a;
  assign busctl.cpu_addr_load_block = st_r.grant_stage_c;
  assign data_out = dbf_own_line(st_r.prio_sel);
  assign data_oe = (timing.time_state_four && st_r.break_request_flop) ?
                   dbf_own_line(st_r.prio_sel) : '0;
  assign mem_addr = st_r.addr;
  assign mem_addr_oe = st_r.grant_stage_a && st_r.grant_stage_b;
  assign video_word = st_r.vid;
  assign read_select = st_r.read_sel;

endmodule : dbf_fetch

`default_nettype wire

// ===== hw/dbf_pkg.sv
/*
  dbf_pkg: constants and carrier types for the display break-fetch engine.
  assumes an APB master on pclk and a shared backplane bus with pulse timing.
*/
package dbf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // apb register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_START = 8'h0C;

  // control register fields
  localparam int CTRL_GRAPHIC = 0;
  localparam int CTRL_CHARS64 = 1;
  localparam int CTRL_PRIO_LO = 2;
  localparam int CTRL_PRIO_W = 2;
  // command register fields
  localparam int CMD_GO = 0;
  localparam int CMD_MAINT_BRK = 1;
  localparam int CMD_MAINT_ON = 2;

  // priority strap codes
  localparam logic [1:0] PRIO_10 = 2'h0;
  localparam logic [1:0] PRIO_11 = 2'h1;
  localparam logic [1:0] PRIO_12 = 2'h2;
  localparam logic [1:0] PRIO_RST = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // data geometry
  localparam int WORD_W = 12;
  localparam int BANK_DEPTH = 32;
  localparam int CNT_W = 7;
  localparam int ADDR_W = 15;
  localparam int BRK_CNT_W = 4;
  localparam logic [WORD_W-1:0] NEWLINE_CODE = 12'h00A;
  localparam logic [CNT_W-1:0] WORDS_ALPHA32 = 7'h20;
  localparam logic [CNT_W-1:0] WORDS_ALPHA64 = 7'h40;
  localparam logic [CNT_W-1:0] WORDS_GRAPHIC = 7'h20;
  localparam logic [WORD_W-1:0] PRIO_LINE_10 = 12'h200;
  localparam logic [WORD_W-1:0] PRIO_LINE_11 = 12'h400;
  localparam logic [WORD_W-1:0] PRIO_LINE_12 = 12'h800;
  localparam logic [WORD_W-1:0] HIGHER_10 = 12'h1FF;
  localparam logic [WORD_W-1:0] HIGHER_11 = 12'h3FF;
  localparam logic [WORD_W-1:0] HIGHER_12 = 12'h7FF;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic time_state_four;
    logic timing_pulse_one;
    logic timing_pulse_four;
    logic int_strobe;
  } dbf_timing_type;

  typedef struct packed {
    logic vsync;
    logic visible_frame_zone;
    logic ten_line_carry;
    logic line_end_tick;
    logic alternate_line_flag;
    logic shift_line_buffer;
  } dbf_video_type;

  typedef struct packed {
    logic cpu_addr_drive_off;
    logic break_pending_line;
    logic cpu_dma_state_force;
    logic break_cycle_ind;
    logic mem_data_direction;
    logic cpu_addr_load_block;
  } dbf_busctl_type;

endpackage : dbf_pkg

// ===== verif/dbf_bus_model.sv
/*
  dbf_bus_model: backplane cpu timing, memory and rival break devices.
  assumes lines read 1 when asserted and idle at 0 through pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module dbf_bus_model #(parameter logic [14:0] NL_ADDR = 15'h0205) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // device side
  input wire logic [11:0] data_out,
  input wire logic [11:0] data_oe,
  input wire logic [14:0] mem_addr,
  input wire logic mem_addr_oe,
  // other break devices
  input wire logic [11:0] rival,
  // bus lines
  output dbf_pkg::dbf_timing_type timing,
  output logic [11:0] data_in,
  output logic [11:0] md_in
);
  logic [3:0] ph;
  logic [11:0] junk;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ph <= 4'h0;
      junk <= 12'h5A5;
    end
    else
    begin
      ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
      junk <= ~junk;
    end
  assign timing.int_strobe = (ph == 4'h0);
  assign timing.time_state_four = (ph == 4'h1) || (ph == 4'h2);
  assign timing.timing_pulse_four = (ph == 4'h3);
  assign timing.timing_pulse_one = (ph == 4'h6);
  // rivals only contend in ts4
  assign data_in = (data_oe & data_out) | (timing.time_state_four ? rival : 12'h000);
  // read-restore leaves memory unchanged
  assign md_in = !mem_addr_oe ? junk : (mem_addr == NL_ADDR) ? 12'h00A : mem_addr[11:0] + 12'h100;
endmodule : dbf_bus_model
`default_nettype wire

// ===== verif/dbf_fetch_chk.sv
/*
  dbf_fetch_chk: bus-side assertions on dbf_fetch.
  assumes one pclk domain and async active-low presetn.
*/
`timescale 1ns/1ps
`default_nettype none
module dbf_fetch_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // watched ports
  input wire dbf_pkg::dbf_timing_type timing,
  input wire logic [11:0] data_out,
  input wire logic [11:0] data_oe,
  input wire logic [14:0] mem_addr,
  input wire logic mem_addr_oe,
  input wire dbf_pkg::dbf_busctl_type busctl
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  sequence s_grant;
    $rose(busctl.mem_data_direction);
  endsequence
  sequence s_stage_c;
    ##[1:20] busctl.cpu_addr_load_block;
  endsequence
  ////////////////////////////////////////////////////////////////
  a_req_drives_bus: assert property (busctl.break_pending_line |-> busctl.cpu_addr_drive_off &&
    (!timing.time_state_four || data_oe != 12'h000))
    else $error("request without address disable");
  a_oe_in_ts4: assert property (
    data_oe != 12'h000 |-> timing.time_state_four && busctl.break_pending_line)
    else $error("priority driven outside ts4");
  a_oe_own_line: assert property (
    data_oe != 12'h000 |-> (data_oe inside {12'h200, 12'h400, 12'h800}) && (data_out & data_oe) == data_oe)
    else $error("bad priority line");
  a_req_at_strobe: assert property ($rose(busctl.break_pending_line) |-> $past(timing.int_strobe))
    else $error("request rose off strobe");
  a_grant_at_tp4: assert property (s_grant |-> $past(timing.timing_pulse_four))
    else $error("grant rose off tp4");
  a_grant_drop: assert property ($fell(busctl.mem_data_direction) |-> $past(timing.timing_pulse_four))
    else $error("grant fell off tp4");
  a_grant_takes_cpu: assert property (
    busctl.mem_data_direction |-> busctl.cpu_dma_state_force && busctl.break_cycle_ind)
    else $error("grant without cpu takeover");
  a_stage_c_follows: assert property (s_grant |-> s_stage_c)
    else $error("stage c missing");
  a_stage_c_tp1: assert property (
    $rose(busctl.cpu_addr_load_block) |-> $past(timing.timing_pulse_one) && busctl.mem_data_direction)
    else $error("stage c off tp1");
  a_addr_step: assert property (
    mem_addr_oe && $past(mem_addr_oe) && mem_addr != $past(mem_addr)
    |-> $past(timing.timing_pulse_four) && mem_addr == $past(mem_addr) + 15'h0001)
    else $error("address step wrong");
endmodule : dbf_fetch_chk
bind dbf_fetch dbf_fetch_chk u_chk (.pclk(pclk), .presetn(presetn), .timing(timing), .data_out(data_out),
  .data_oe(data_oe), .mem_addr(mem_addr), .mem_addr_oe(mem_addr_oe), .busctl(busctl));
`default_nettype wire

// ===== verif/dbf_fetch_test.sv
/*
  dbf_fetch_test: self-checking bench for dbf_fetch.
  assumes dbf_bus_model as backplane and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module dbf_fetch_test;
  localparam logic [5:0] V_VS = 6'h20;
  localparam logic [5:0] V_ZONE = 6'h10;
  localparam logic [5:0] V_CARRY = 6'h08;
  localparam logic [5:0] V_LEND = 6'h04;
  localparam logic [5:0] V_ALT = 6'h02;
  localparam logic [5:0] V_SHIFT = 6'h01;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, eos, mem_addr_oe, read_select, s;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [5:0] vid;
  logic [11:0] rival, data_in, data_out, data_oe, md_in, video_word;
  logic [14:0] mem_addr;
  dbf_pkg::dbf_timing_type tim;
  dbf_pkg::dbf_busctl_type bc;
  int num_errors = 0;
  int n_compared = 0;
  dbf_fetch uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timing(tim), .video(vid), .end_screen_code_hit(eos), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .md_in(md_in), .mem_addr(mem_addr), .mem_addr_oe(mem_addr_oe), .busctl(bc),
    .video_word(video_word), .read_select(read_select));
  dbf_bus_model u_bus (.pclk(pclk), .presetn(presetn), .data_out(data_out), .data_oe(data_oe),
    .mem_addr(mem_addr), .mem_addr_oe(mem_addr_oe), .rival(rival), .timing(tim), .data_in(data_in),
    .md_in(md_in));
  ////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic hang;
    $display("BAD wait expected done seen timeout");
    num_errors++;
    test_done;
  endtask : hang
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", what, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 50)
      hang;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pulse(input logic [5:0] lvl, input logic [5:0] m);
    @(posedge pclk);
    vid <= lvl | m;
    @(posedge pclk);
    vid <= lvl;
  endtask : pulse
  task automatic idle;
    int n, k = 0;
    for (n = 0; n < 4000 && k < 24; n++)
    begin
      @(negedge pclk);
      k = (bc.break_pending_line === 1'b0 && bc.mem_data_direction === 1'b0) ? k + 1 : 0;
    end
    if (k < 24)
      hang;
  endtask : idle
  task automatic start(input logic [31:0] c, input logic [31:0] a);
    apb(1'b1, dbf_pkg::ADDR_CTRL, c, q);
    apb(1'b1, dbf_pkg::ADDR_START, a, q);
    apb(1'b1, dbf_pkg::ADDR_CMD, 32'h1, q);
    pulse(6'h00, V_VS);
  endtask : start
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    apb(1'b0, dbf_pkg::ADDR_STATUS, 32'h0, q);
    chk("status", 32'h1, q & 32'h1F);
    apb(1'b0, dbf_pkg::ADDR_CTRL, 32'h0, q);
    chk("ctrl", {28'h0, dbf_pkg::PRIO_RST, 2'h0}, q);
    apb(1'b0, 8'h10, 32'h0, q);
    chk("slverr", 32'h1, {31'h0, err});
    $display("test reset done");
  endtask : t_reset
  task automatic t_alpha;
    start(32'h0, 32'h40);
    pulse(V_ZONE, V_CARRY);
    idle();
    chk("fill32 addr", 32'h60, {17'h0, mem_addr});
    chk("bank b", 32'h1, {31'h0, read_select});
    chk("first word", 32'h140, {20'h0, video_word});
    repeat (32) pulse(V_ZONE, V_SHIFT);
    repeat (3) @(negedge pclk);
    chk("recirc word", 32'h140, {20'h0, video_word});
    pulse(V_ZONE, V_SHIFT);
    repeat (3) @(negedge pclk);
    chk("next word", 32'h141, {20'h0, video_word});
    start(32'h2, 32'h80);
    pulse(V_ZONE, V_CARRY);
    idle();
    chk("fill64 addr", 32'hC0, {17'h0, mem_addr});
    $display("test alpha done");
  endtask : t_alpha
  task automatic t_graphic;
    start(32'h1, 32'h100);
    pulse(V_ZONE, V_LEND);
    idle();
    chk("odd line", 32'h100, {17'h0, mem_addr});
    s = read_select;
    pulse(V_ZONE | V_ALT, V_LEND);
    idle();
    chk("graphic fill", 32'h120, {17'h0, mem_addr});
    chk("bank swap", {31'h0, ~s}, {31'h0, read_select});
    $display("test graphic done");
  endtask : t_graphic
  task automatic t_stop;
    start(32'h0, 32'h200);
    pulse(V_ZONE, V_CARRY);
    idle();
    chk("newline stop", 32'h1, {31'h0, mem_addr inside {15'h206, 15'h207}});
    apb(1'b0, dbf_pkg::ADDR_STATUS, 32'h0, q);
    chk("newline flag", 32'h200, q & 32'h202);
    start(32'h0, 32'h300);
    pulse(6'h00, V_CARRY);
    idle();
    chk("zone off", 32'h300, {17'h0, mem_addr});
    @(posedge pclk);
    eos <= 1'b1;
    pulse(V_ZONE, V_CARRY);
    idle();
    chk("end code", 32'h300, {17'h0, mem_addr});
    pulse(V_ZONE, V_VS);
    eos <= 1'b0;
    repeat (40) @(negedge pclk);
    chk("vsync clear", 32'h300, {17'h0, mem_addr});
    pulse(V_ZONE, V_CARRY);
    repeat (60) @(negedge pclk);
    pulse(V_ZONE, V_VS);
    idle();
    chk("vsync stop", 32'h1, {31'h0, mem_addr > 15'h300 && mem_addr < 15'h320});
    $display("test stop done");
  endtask : t_stop
  task automatic t_prio;
    logic [11:0] own;
    logic [14:0] a0;
    int n;
    for (int p = 0; p < 3; p++)
    begin
      own = dbf_pkg::PRIO_LINE_10 << p;
      apb(1'b1, dbf_pkg::ADDR_CTRL, 32'(p) << dbf_pkg::CTRL_PRIO_LO, q);
      rival <= own >> 1;
      a0 = mem_addr;
      apb(1'b1, dbf_pkg::ADDR_CMD, 32'h6, q);
      n = 0;
      while (!(tim.time_state_four === 1'b1 && bc.break_pending_line === 1'b1) && n < 100)
      begin
        @(negedge pclk);
        n++;
      end
      if (n == 100)
        hang;
      chk("prio line", {20'h0, own}, {20'h0, data_oe});
      repeat (40) @(negedge pclk);
      chk("withheld", {17'h0, a0}, {17'h0, mem_addr});
      @(posedge pclk);
      rival <= 12'h000;
      idle();
      chk("one break", {17'h0, a0 + 15'h1}, {17'h0, mem_addr});
    end
    $display("test prio done");
  endtask : t_prio
  ////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    vid = 6'h00;
    eos = 1'b0;
    rival = 12'h000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_alpha;
    t_graphic;
    t_stop;
    t_prio;
    test_done;
  end
endmodule : dbf_fetch_test
`default_nettype wire
